//--- src/sctc_top.sv
// System clock timing controller: prescaler, divider chain, machine
// cycle counter, operating mode control and APB registers.
// Assumes CLK is the high frequency clock; the low frequency clock and
// the stop release arrive as pins and are synchronised here.
//
// How it works
// RULE1: 2-stage prescaler, 21-stage divider, main clock and cycle counters.
// RULE2: prescaler and divider clear on reset, STOP entry and STOP release.
// RULE3: stage seven input picks by mode, clock select and source select.
// RULE4: low-speed run and halt feed the low clock to stage seven.
// RULE5: warm-up after STOP from full speed feeds stage six to stage seven.
// RULE6: software keeps the stage seven source select clear in single mode.
// RULE7: software sets that select only once the low oscillator is stable.
// RULE8: a machine cycle is four states, each one main clock step.
// RULE9: instructions last one to ten machine cycles.
// RULE10: CPU and peripherals step on the main system clock enable.
// RULE11: outputs main clock, divider pulse, stage ticks and warm-up timing.
// RULE12: mode control runs oscillators over single, dual and stop modes.
// RULE13: single mode runs only the high oscillator, four ticks per cycle.
// RULE14: single mode frees the low oscillator pins as port bits.
// RULE15: reset enters full-speed single mode.
// RULE16: single halt keeps peripherals clocked, stops CPU and watchdog.
// RULE17: idle bit write halts; any interrupt request wakes to full speed; the code wakes low halt to low-speed run.
// RULE18: wake with interrupts enabled accepts the waking interrupt.
// RULE19: wake with interrupts disabled resumes at the next instruction.
// RULE20: low-speed modes step the main clock from the low clock.
// RULE21: a one-cycle strobe marks the last state of each cycle.
module sctc_top (
  input  wire logic        CLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        LOW_FREQ_OSC_IN,
  input  wire logic        STOP_RELEASE,
  input  wire logic        INT_REQ,
  input  wire logic        INTERRUPT_MASTER_ENABLE,
  input  wire logic [3:0]  INSTR_LEN,
  output logic             CPU_CLK_EN,
  output logic             PERIPH_CLK_EN,
  output logic             WDT_CLK_EN,
  output logic             CYCLE_END,
  output logic             INSTR_DONE,
  output logic [1:0]       MACHINE_STATE,
  output logic [20:0]      STAGE_TICK,
  output logic             DIVIDER_OUTPUT_PULSE,
  output logic             WARMUP_ACTIVE,
  output logic             HIGH_OSC_RUN,
  output logic             LOW_OSC_RUN,
  output logic             LOW_OSC_PINS_GPIO,
  output logic             IRQ_ACCEPT,
  output logic             RESUME_NEXT
);

  localparam int LW = sctc_pkg::LOW_STAGES;
  localparam int HW = sctc_pkg::HIGH_STAGES;

  // Registers and state
  logic [7:0]             sc1_r;
  logic [7:0]             sc2_r;
  logic [7:0]             tb_r;
  sctc_pkg::sctc_mode_t   mode_r;
  sctc_pkg::sctc_mode_t   mode_nxt;
  logic                   warm_full_r;
  logic                   fs_s1_r;
  logic                   fs_s2_r;
  logic                   fs_d_r;
  logic                   rel_s1_r;
  logic                   rel_s2_r;
  logic [20:0]            div_prev_r;

  // Divider wiring
  logic [1:0]             pre_val;
  logic                   pre_carry;
  logic [LW-1:0]          low_val;
  logic                   low_carry;
  logic [HW-1:0]          high_val;
  logic                   high_carry;
  logic [20:0]            div_val;
  logic                   div_clr;
  logic                   fc_tick;
  logic                   fs_tick;
  logic                   st7_tick;
  logic                   msys_tick;

  // Mode decode
  logic                   m_single;
  logic                   m_low;
  logic                   m_halt;
  logic                   m_cpu;
  logic                   m_frozen;
  logic                   xen;
  logic                   xten;
  logic                   system_clock_select;
  logic                   dv7;
  logic                   stop_req;
  logic                   idle_req;
  logic                   wake;
  logic                   warm_done;
  logic                   stop_rel;

  // Bus decode
  logic                   acc;
  logic                   wr;
  logic                   hit_sc1;
  logic                   hit_sc2;
  logic                   hit_tb;
  logic                   hit_st;
  logic                   hit_dv;
  logic                   mapped;

  sctc_mc_if              mc ();

  // APB decode; zero wait states, unmapped offsets flag an error
  assign acc     = PSEL & PENABLE;
  assign wr      = acc & PWRITE;
  assign hit_sc1 = (PADDR == sctc_pkg::OFS_SYSCTL1);
  assign hit_sc2 = (PADDR == sctc_pkg::OFS_SYSCTL2);
  assign hit_tb  = (PADDR == sctc_pkg::OFS_TBCTL);
  assign hit_st  = (PADDR == sctc_pkg::OFS_STATUS);
  assign hit_dv  = (PADDR == sctc_pkg::OFS_DIVVAL);
  assign mapped  = hit_sc1 | hit_sc2 | hit_tb | hit_st | hit_dv;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc & ~mapped;

  // Read data selection
  assign PRDATA = hit_sc1 ? {24'h0, sc1_r} :
                  hit_sc2 ? {24'h0, sc2_r} :
                  hit_tb  ? {24'h0, tb_r} :
                  hit_st  ? {22'h0, mc.state, 8'(mode_r)} :
                  hit_dv  ? {11'h0, div_val} : 32'h0;

  // Control fields
  assign xen   = sc2_r[sctc_pkg::SC2_XEN_BIT];
  assign xten  = sc2_r[sctc_pkg::SC2_XTEN_BIT];
  assign system_clock_select = sc2_r[sctc_pkg::SC2_SYSTEM_CLOCK_SELECT_BIT];
  assign dv7   = tb_r[sctc_pkg::TB_DV7_BIT];

  // Stop and idle requests come from register writes
  assign stop_req = wr & hit_sc1 & PWDATA[sctc_pkg::SC1_STOP_BIT];  // RULE12
  assign idle_req = wr & hit_sc2 & PWDATA[sctc_pkg::SC2_IDLE_BIT];  // RULE17

  // Mode groups
  assign m_single = (mode_r == sctc_pkg::MODE_FULL_SINGLE) |
                    (mode_r == sctc_pkg::MODE_HALT_SINGLE);
  assign m_low    = (mode_r == sctc_pkg::MODE_LOW_RUN) |
                    (mode_r == sctc_pkg::MODE_LOW_HALT);
  assign m_halt   = (mode_r == sctc_pkg::MODE_HALT_SINGLE) |
                    (mode_r == sctc_pkg::MODE_HALT_DUAL) |
                    (mode_r == sctc_pkg::MODE_LOW_HALT);
  assign m_frozen = (mode_r == sctc_pkg::MODE_STOP) |
                    (mode_r == sctc_pkg::MODE_WARM);
  assign m_cpu    = ~m_halt & ~m_frozen;

  // Any interrupt request ends a halt mode
  assign wake = m_halt & INT_REQ;                                   // RULE17

  // Low clock edge and stop release, both from pins
  assign fs_tick  = fs_s2_r & ~fs_d_r & xten;
  assign stop_rel = rel_s2_r;

  // High clock ticks while its oscillator runs and the chip is awake
  assign fc_tick = (m_single | xen) & (mode_r != sctc_pkg::MODE_STOP) &
                   ~(m_low & ~xen);

  // Stage seven source selection
  assign st7_tick =
    (mode_r == sctc_pkg::MODE_STOP) ? 1'b0 :
    ((mode_r == sctc_pkg::MODE_WARM) & warm_full_r) ? low_carry :   // RULE5
    (m_low | (mode_r == sctc_pkg::MODE_WARM)) ? fs_tick :           // RULE4
    (dv7 & ~m_single) ? fs_tick : low_carry;                        // RULE3

  // Main system clock: every CLK in high modes, low clock edges in low
  assign msys_tick = m_frozen ? 1'b0 :
                     m_low ? fs_tick :                              // RULE20
                     1'b1;                                          // RULE13

  // Warm-up ends on the selected upper divider bit
  assign warm_done = high_val[sctc_pkg::warm_bit(
                       sc1_r[sctc_pkg::SC1_WSEL_LO +: 2])];         // RULE11

  // Clear on reset, STOP entry and STOP release
  assign div_clr = SRST |
                   (stop_req & ~m_frozen & ~m_halt) |
                   ((mode_r == sctc_pkg::MODE_STOP) & stop_rel);    // RULE2

  assign div_val = {high_val, low_val};

  // Prescaler, stages 1 to 6, stages 7 to 21
  sctc_divcnt #(.W(sctc_pkg::PRE_STAGES)) u_pre (                   // RULE1
    .CLK   (CLK),
    .clr   (div_clr),
    .tick  (fc_tick),
    .value (pre_val),
    .carry (pre_carry)
  );

  sctc_divcnt #(.W(LW)) u_low (
    .CLK   (CLK),
    .clr   (div_clr),
    .tick  (pre_carry),
    .value (low_val),
    .carry (low_carry)
  );

  sctc_divcnt #(.W(HW)) u_high (
    .CLK   (CLK),
    .clr   (div_clr),
    .tick  (st7_tick),
    .value (high_val),
    .carry (high_carry)
  );

  // Machine cycle counter steps only while the CPU runs
  assign mc.state_tick = msys_tick & m_cpu;                         // RULE10
  assign mc.len        = INSTR_LEN;

  sctc_mcycle u_mc (
    .CLK  (CLK),
    .SRST (SRST),
    .mc   (mc)
  );

  // Combinational strobes toward the CPU and peripherals
  assign CPU_CLK_EN    = mc.state_tick;                             // RULE10
  assign PERIPH_CLK_EN = msys_tick;                                 // RULE16
  assign WDT_CLK_EN    = mc.state_tick;                             // RULE16
  assign CYCLE_END     = mc.cyc_end;                                // RULE21
  assign INSTR_DONE    = mc.instr_done;

  // Mode transitions
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      sctc_pkg::MODE_FULL_SINGLE: begin
        if (stop_req) mode_nxt = sctc_pkg::MODE_STOP;
        else if (idle_req) mode_nxt = sctc_pkg::MODE_HALT_SINGLE;   // RULE17
        else if (xten) mode_nxt = sctc_pkg::MODE_FULL_DUAL;         // RULE12
      end
      sctc_pkg::MODE_FULL_DUAL: begin
        if (stop_req) mode_nxt = sctc_pkg::MODE_STOP;
        else if (idle_req) mode_nxt = sctc_pkg::MODE_HALT_DUAL;
        else if (system_clock_select) mode_nxt = sctc_pkg::MODE_LOW_RUN;
        else if (!xten) mode_nxt = sctc_pkg::MODE_FULL_SINGLE;
      end
      sctc_pkg::MODE_LOW_RUN: begin
        if (stop_req) mode_nxt = sctc_pkg::MODE_STOP;
        else if (idle_req) mode_nxt = sctc_pkg::MODE_LOW_HALT;
        else if (!system_clock_select && xen) mode_nxt = sctc_pkg::MODE_FULL_DUAL;
      end
      sctc_pkg::MODE_HALT_SINGLE: begin
        if (wake) mode_nxt = sctc_pkg::MODE_FULL_SINGLE;            // RULE17
      end
      sctc_pkg::MODE_HALT_DUAL: begin
        if (wake) mode_nxt = sctc_pkg::MODE_FULL_DUAL;
      end
      sctc_pkg::MODE_LOW_HALT: begin
        if (wake) mode_nxt = sctc_pkg::MODE_LOW_RUN;
      end
      sctc_pkg::MODE_STOP: begin
        if (stop_rel) mode_nxt = sctc_pkg::MODE_WARM;
      end
      sctc_pkg::MODE_WARM: begin
        if (warm_done) begin
          if (!warm_full_r) mode_nxt = sctc_pkg::MODE_LOW_RUN;
          else if (xten) mode_nxt = sctc_pkg::MODE_FULL_DUAL;
          else mode_nxt = sctc_pkg::MODE_FULL_SINGLE;
        end
      end
      default: mode_nxt = sctc_pkg::MODE_FULL_SINGLE;
    endcase
  end

  // Mode register; reset lands in full-speed single mode
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_r      <= sctc_pkg::MODE_FULL_SINGLE;                    // RULE15
      warm_full_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      if (stop_req && mode_nxt == sctc_pkg::MODE_STOP) begin
        warm_full_r <= ~m_low;
      end
    end
  end

  // System control one; stop bit clears itself after the warm-up
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sc1_r <= sctc_pkg::SC1_RST;
    end else if (wr && hit_sc1) begin
      sc1_r <= PWDATA[7:0];
    end else if (mode_r == sctc_pkg::MODE_WARM && warm_done) begin
      sc1_r[sctc_pkg::SC1_STOP_BIT] <= 1'b0;
    end
  end

  // System control two; idle bit clears itself on wake
  always_ff @(posedge CLK) begin
    if (SRST) begin
      sc2_r <= sctc_pkg::SC2_RST;
    end else if (wake) begin
      sc2_r[sctc_pkg::SC2_IDLE_BIT] <= 1'b0;                       // RULE17
    end else if (wr && hit_sc2) begin
      sc2_r <= PWDATA[7:0];
    end
  end

  // Time base control
  always_ff @(posedge CLK) begin
    if (SRST) begin
      tb_r <= sctc_pkg::TB_RST;
    end else if (wr && hit_tb) begin
      tb_r <= PWDATA[7:0];
    end
  end

  // Pin synchronisers and low clock edge history
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fs_s1_r  <= 1'b0;
      fs_s2_r  <= 1'b0;
      fs_d_r   <= 1'b0;
      rel_s1_r <= 1'b0;
      rel_s2_r <= 1'b0;
    end else begin
      fs_s1_r  <= LOW_FREQ_OSC_IN;
      fs_s2_r  <= fs_s1_r;
      fs_d_r   <= fs_s2_r;
      rel_s1_r <= STOP_RELEASE;
      rel_s2_r <= rel_s1_r;
    end
  end

  // Registered outputs: stage ticks, divider output, oscillators, wake
  always_ff @(posedge CLK) begin
    if (SRST) begin
      div_prev_r           <= 21'h0;
      STAGE_TICK           <= 21'h0;
      DIVIDER_OUTPUT_PULSE <= 1'b0;
      WARMUP_ACTIVE        <= 1'b0;
      HIGH_OSC_RUN         <= 1'b1;
      LOW_OSC_RUN          <= 1'b0;
      LOW_OSC_PINS_GPIO    <= 1'b1;
      IRQ_ACCEPT           <= 1'b0;
      RESUME_NEXT          <= 1'b0;
      MACHINE_STATE        <= 2'h0;
    end else begin
      div_prev_r           <= div_val;
      STAGE_TICK           <= div_val & ~div_prev_r;                // RULE11
      DIVIDER_OUTPUT_PULSE <= high_val[sctc_pkg::dvo_bit(
                                tb_r[sctc_pkg::TB_DVOSEL_LO +: 3])]; // RULE11
      WARMUP_ACTIVE        <= (mode_nxt == sctc_pkg::MODE_WARM);
      HIGH_OSC_RUN         <= (mode_nxt != sctc_pkg::MODE_STOP) &
                              (xen | m_single);                     // RULE13
      LOW_OSC_RUN          <= xten & (mode_nxt != sctc_pkg::MODE_STOP);
      LOW_OSC_PINS_GPIO    <= ~xten;                                // RULE14
      IRQ_ACCEPT           <= wake & INTERRUPT_MASTER_ENABLE;       // RULE18
      RESUME_NEXT          <= wake & ~INTERRUPT_MASTER_ENABLE;      // RULE19
      MACHINE_STATE        <= mc.state;
    end
  end

endmodule // sctc_top

//--- src/sctc_pkg.sv
// Package of the system clock timing controller: offsets, fields,
// reset values, counts and the operating mode encoding.
// Assumes one 40 MHz clock and an APB register port.
package sctc_pkg;

  // Clock rate of CLK
  localparam int CLK_HZ = 40_000_000;

  // Divider geometry: prescaler, stages 1 to 6, stages 7 to 21
  localparam int PRE_STAGES  = 2;
  localparam int LOW_STAGES  = 6;
  localparam int DIV_STAGES  = 21;
  localparam int HIGH_STAGES = DIV_STAGES - LOW_STAGES;

  // Machine cycle figures
  localparam int MC_STATES  = 4;
  localparam int MC_MAX_LEN = 10;

  // Register byte offsets
  localparam logic [7:0] OFS_SYSCTL1 = 8'h00;
  localparam logic [7:0] OFS_SYSCTL2 = 8'h04;
  localparam logic [7:0] OFS_TBCTL   = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_DIVVAL  = 8'h10;

  // Field positions
  localparam int SC1_STOP_BIT  = 7;
  localparam int SC1_WSEL_LO   = 0;
  localparam int SC2_XEN_BIT   = 7;
  localparam int SC2_XTEN_BIT  = 6;
  localparam int SC2_SYSTEM_CLOCK_SELECT_BIT = 5;
  localparam int SC2_IDLE_BIT  = 4;
  localparam int TB_DV7_BIT    = 3;
  localparam int TB_DVOSEL_LO  = 0;
  localparam int STAT_STATE_LO = 8;

  // Reset values
  localparam logic [7:0] SC1_RST = 8'h00;
  localparam logic [7:0] SC2_RST = 8'h80;
  localparam logic [7:0] TB_RST  = 8'h00;

  // Operating modes, one-hot
  typedef enum logic [7:0] {
    MODE_FULL_SINGLE = 8'h01,
    MODE_HALT_SINGLE = 8'h02,
    MODE_FULL_DUAL   = 8'h04,
    MODE_HALT_DUAL   = 8'h08,
    MODE_LOW_RUN     = 8'h10,
    MODE_LOW_HALT    = 8'h20,
    MODE_STOP        = 8'h40,
    MODE_WARM        = 8'h80
  } sctc_mode_t;

  // Upper-divider bit that ends the warm-up, by warm-up select
  function automatic logic [3:0] warm_bit(input logic [1:0] sel);
    warm_bit = 4'he - {1'b0, sel, 1'b0};
  endfunction

  // Upper-divider bit driven out as the divider output, by select
  function automatic logic [3:0] dvo_bit(input logic [2:0] sel);
    dvo_bit = {1'b0, sel} + 4'h3;
  endfunction

endpackage

//--- src/sctc_mc_if.sv
// Carrier between the timing controller and its machine cycle counter.
// Assumes both ends share CLK and SRST.
interface sctc_mc_if;
  logic       state_tick;  // Main system clock step while the CPU runs
  logic [3:0] len;         // Machine cycles of the current instruction
  logic [1:0] state;       // Current state S0..S3
  logic       cyc_end;     // Last state of a machine cycle
  logic       instr_done;  // Last state of an instruction

  modport ctl (output state_tick, len, input state, cyc_end, instr_done);
  modport cnt (input state_tick, len, output state, cyc_end, instr_done);
endinterface

//--- src/sctc_divcnt.sv
// Synchronous binary divider segment with clear and carry.
// Assumes tick is a one-cycle enable on CLK.
module sctc_divcnt #(
  parameter int W = 6
) (
  input  wire logic         CLK,
  input  wire logic         clr,
  input  wire logic         tick,
  output logic [W-1:0]      value,
  output logic              carry
);

  // Carry when the segment wraps on this tick
  assign carry = tick & (&value);

  // Count up on each tick, clear wins
  always_ff @(posedge CLK) begin
    if (clr) begin
      value <= '0;
    end else if (tick) begin
      value <= value + 1'b1;
    end
  end

endmodule // sctc_divcnt

//--- src/sctc_mcycle.sv
// Machine cycle counter: four states per cycle, one to ten cycles.
// Assumes state_tick is a one-cycle enable on CLK.
module sctc_mcycle (
  input  wire logic CLK,
  input  wire logic SRST,
  sctc_mc_if.cnt    mc
);

  logic [1:0] state_r;
  logic [3:0] cyc_r;
  logic [3:0] len_r;
  logic [3:0] len_lim;

  // Length held to 1..10 cycles
  assign len_lim = (mc.len == 4'h0) ? 4'h1 :
                   (mc.len > 4'(sctc_pkg::MC_MAX_LEN)) ?
                   4'(sctc_pkg::MC_MAX_LEN) : mc.len;            // RULE9

  // Strobes at the last state of cycle and of instruction
  assign mc.state      = state_r;
  assign mc.cyc_end    = mc.state_tick &
                         (state_r == 2'(sctc_pkg::MC_STATES - 1)); // RULE21
  assign mc.instr_done = mc.cyc_end & (cyc_r == len_r - 4'h1);     // RULE9

  // One state per main system clock step
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= 2'h0;
      cyc_r   <= 4'h0;
      len_r   <= 4'h1;
    end else if (mc.state_tick) begin
      state_r <= state_r + 2'h1;                                   // RULE8
      if (mc.instr_done) begin
        cyc_r <= 4'h0;
      end else if (mc.cyc_end) begin
        cyc_r <= cyc_r + 4'h1;
      end
      if (state_r == 2'h0 && cyc_r == 4'h0) begin
        len_r <= len_lim;
      end
    end
  end

endmodule // sctc_mcycle

//--- verif/sctc_chk_properties.sv
// Port-level assertions for the system clock timing controller.
// Assumes it is bound into sctc_top and sees only that module's ports.
module sctc_chk (
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic        PSLVERR,
  input wire logic        INT_REQ,
  input wire logic        INTERRUPT_MASTER_ENABLE,
  input wire logic        CPU_CLK_EN,
  input wire logic        PERIPH_CLK_EN,
  input wire logic        WDT_CLK_EN,
  input wire logic        CYCLE_END,
  input wire logic        INSTR_DONE,
  input wire logic [1:0]  MACHINE_STATE,
  input wire logic [20:0] STAGE_TICK,
  input wire logic        HIGH_OSC_RUN,
  input wire logic        LOW_OSC_RUN,
  input wire logic        LOW_OSC_PINS_GPIO,
  input wire logic        IRQ_ACCEPT,
  input wire logic        RESUME_NEXT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);

  // Bus error only in the access phase of an unmapped word
  a_bus_error: assert property (PSEL && PENABLE |->
    PSLVERR == (PADDR > 8'h10 || PADDR[1:0] != 2'h0))
    else $error("bus error flag off the address map");
  // Machine cycle steps through four states in order
  a_state_step: assert property ($changed(MACHINE_STATE) |->
    MACHINE_STATE == $past(MACHINE_STATE) + 2'h1)
    else $error("machine state skipped a step");
  a_cycle_four: assert property (
    CYCLE_END && CPU_CLK_EN ##1 CPU_CLK_EN[*4] |-> CYCLE_END &&
    !$past(CYCLE_END) && !$past(CYCLE_END, 2) && !$past(CYCLE_END, 3))
    else $error("machine cycle is not four main clock steps");
  a_end_strobe: assert property (CYCLE_END |=> !CYCLE_END)
    else $error("cycle end strobe longer than one clock");
  a_done_end: assert property (INSTR_DONE |-> CYCLE_END)
    else $error("instruction ended off a cycle boundary");
  // Watchdog halts together with the CPU
  a_wdt_cpu: assert property (WDT_CLK_EN == CPU_CLK_EN)
    else $error("watchdog step differs from CPU step");
  a_pins_free: assert property (LOW_OSC_PINS_GPIO |-> !LOW_OSC_RUN)
    else $error("low oscillator runs while its pins are ports");
  // Wake from the single halt mode one clock after the request
  a_wake_next: assert property (
    !CPU_CLK_EN && PERIPH_CLK_EN && LOW_OSC_PINS_GPIO && INT_REQ |=>
    CPU_CLK_EN && (IRQ_ACCEPT != RESUME_NEXT))
    else $error("halt mode did not wake on request");
  a_accept_ime: assert property (IRQ_ACCEPT |->
    $past(INT_REQ) && $past(INTERRUPT_MASTER_ENABLE))
    else $error("interrupt accepted without enable");
  a_resume_ime: assert property (RESUME_NEXT |->
    $past(INT_REQ) && !$past(INTERRUPT_MASTER_ENABLE))
    else $error("resume taken with interrupts enabled");
  a_stop_still: assert property (
    (!HIGH_OSC_RUN && !LOW_OSC_RUN)[*2] |-> STAGE_TICK == 21'h0)
    else $error("divider moved with both oscillators stopped");
endmodule // sctc_chk

bind sctc_top sctc_chk u_chk (.*);

//--- verif/sctc_cpu_model.sv
// Model of the far side: low frequency crystal and a waking peripheral.
// Assumes CLK is the controller clock; the crystal runs at CLK / 16.
module sctc_cpu_model (
  input  wire logic CLK,
  input  wire logic SRST,
  input  wire logic want_irq,
  input  wire logic cpu_clk_en,
  input  wire logic periph_clk_en,
  input  wire logic woke,
  output logic      fs_clk,
  output logic      int_req
);
  logic [2:0] div_r;

  // Free running low clock, sixteen CLK periods each
  always_ff @(posedge CLK) begin
    if (SRST) begin
      div_r <= 3'h0;
      fs_clk <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'h7) fs_clk <= !fs_clk;
    end
  end

  // Request raised once the CPU halts, dropped when the wake is served
  always_ff @(posedge CLK) begin
    if (SRST || woke) begin
      int_req <= 1'b0;
    end else if (want_irq && !cpu_clk_en && periph_clk_en) begin
      int_req <= 1'b1;
    end
  end
endmodule // sctc_cpu_model

//--- verif/tb_top.sv
// Self-checking bench of the system clock timing controller.
// Assumes the partner model supplies the low clock and wake requests.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, SRST, PSEL, PENABLE, PWRITE, STOP_RELEASE, serr;
  logic        INTERRUPT_MASTER_ENABLE, want_irq, PREADY, PSLVERR;
  logic        LOW_FREQ_OSC_IN, INT_REQ, CPU_CLK_EN, PERIPH_CLK_EN;
  logic        WDT_CLK_EN, CYCLE_END, INSTR_DONE, DIVIDER_OUTPUT_PULSE;
  logic        WARMUP_ACTIVE, HIGH_OSC_RUN, LOW_OSC_RUN, LOW_OSC_PINS_GPIO;
  logic        IRQ_ACCEPT, RESUME_NEXT;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [3:0]  INSTR_LEN;
  logic [1:0]  MACHINE_STATE;
  logic [20:0] STAGE_TICK;
  int          error_cnt, checks_done, n;

  sctc_top dut (.*);
  sctc_cpu_model u_cpu (.CLK, .SRST, .want_irq, .cpu_clk_en(CPU_CLK_EN),
    .periph_clk_en(PERIPH_CLK_EN), .woke(IRQ_ACCEPT || RESUME_NEXT),
    .fs_clk(LOW_FREQ_OSC_IN), .int_req(INT_REQ));

  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task close_out;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 16);
    rdat = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    chk("pready", 1'b1, PREADY);
    if (PREADY !== 1'b1) close_out;
  endtask

  task rd(input string nm, input logic [7:0] a, input logic [31:0] e,
          input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask

  function automatic logic ev(input int k);
    case (k)
      0: ev = CYCLE_END;
      1: ev = INSTR_DONE;
      2: ev = WARMUP_ACTIVE;
      3: ev = !WARMUP_ACTIVE;
      4: ev = CPU_CLK_EN;
      5: ev = STAGE_TICK[6];
      7: ev = DIVIDER_OUTPUT_PULSE;
      default: ev = STAGE_TICK[0];
    endcase
  endfunction

  // Counts clocks until an event, bounded
  task wt(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(posedge CLK);
      #1;
      c++;
    end while (ev(k) !== 1'b1 && c < lim);
    if (ev(k) !== 1'b1) begin
      error_cnt++;
      $display("unexpected timeout event %0d expected 1 seen 0", k);
      close_out;
    end
  endtask

  task t_reset;
    rd("ctl1_rst", 8'h00, {24'h0, sctc_pkg::SC1_RST}, '1);
    rd("ctl2_rst", 8'h04, {24'h0, sctc_pkg::SC2_RST}, '1);
    rd("tb_rst", 8'h08, {24'h0, sctc_pkg::TB_RST}, '1);
    rd("mode_rst", 8'h0c, 32'h1, 32'hff);
    chk("osc_rst", 3'b101, {HIGH_OSC_RUN, LOW_OSC_RUN, LOW_OSC_PINS_GPIO});
    apb(1'b1, 8'h40, 32'hff);
    chk("slverr", 1'b1, serr);
    rd("unmapped", 8'h40, 32'h0, '1);
    wt(0, 16, n);
    wt(0, 16, n);
    chk("cycle_len", 4, n);
    wt(6, 16, n);
    wt(6, 16, n);
    chk("stage1_gap", 8, n);
    wt(5, 600, n);
    wt(5, 600, n);
    chk("stage7_gap", 512, n);
    $display("test reset done");
  endtask

  task t_instr;
    static logic [3:0] lens [4] = '{4'h0, 4'h1, 4'ha, 4'hf};
    int e;
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      INSTR_LEN <= lens[i];
      e = lens[i] == 4'h0 ? 1 : (lens[i] > 4'ha ? 10 : int'(lens[i]));
      wt(1, 64, n);
      wt(1, 64, n);
      chk("instr_len", 4 * e, n);
    end
    $display("test instr done");
  endtask

  task t_idle;
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK);
      INTERRUPT_MASTER_ENABLE <= i[0];
      apb(1'b1, 8'h04, 32'h90);
      repeat (2) @(posedge CLK);
      #1;
      chk("halt_en", 3'b010, {CPU_CLK_EN, PERIPH_CLK_EN, WDT_CLK_EN});
      rd("halt_mode", 8'h0c, 32'h2, 32'hff);
      want_irq <= 1'b1;
      wt(4, 16, n);
      chk("wake", i ? 2'b10 : 2'b01, {IRQ_ACCEPT, RESUME_NEXT});
      @(posedge CLK);
      want_irq <= 1'b0;
      rd("idle_clr", 8'h04, 32'h80, '1);
    end
    $display("test idle done");
  endtask

  task t_low;
    apb(1'b1, 8'h04, 32'hc0);
    repeat (64) @(posedge CLK); // Low oscillator settles first
    chk("dual_osc", 3'b110, {HIGH_OSC_RUN, LOW_OSC_RUN, LOW_OSC_PINS_GPIO});
    rd("dual_mode", 8'h0c, 32'h4, 32'hff);
    apb(1'b1, 8'h08, 32'h08);
    wt(5, 600, n);
    wt(5, 64, n);
    wt(5, 64, n);
    chk("stage7_fs", 32, n);
    apb(1'b1, 8'h04, 32'he0);
    rd("low_mode", 8'h0c, 32'h10, 32'hff);
    wt(0, 100, n);
    wt(0, 100, n);
    chk("low_cycle", 64, n);
    apb(1'b1, 8'h08, 32'h0);
    wt(5, 64, n);
    wt(5, 64, n);
    chk("stage7_low", 32, n);
    apb(1'b1, 8'h04, 32'hc0);
    apb(1'b1, 8'h04, 32'h80);
    rd("back_mode", 8'h0c, 32'h1, 32'hff);
    $display("test low done");
  endtask

  task t_stop;
    apb(1'b1, 8'h00, 32'h83);
    rd("stop_mode", 8'h0c, 32'h40, 32'hff);
    rd("stop_div", 8'h10, 32'h0, '1);
    STOP_RELEASE <= 1'b1;
    wt(2, 16, n);
    wt(3, 70000, n);
    chk("warm_len", 64, n / 1024);
    wt(7, 2100, n);
    chk("dvo_rise", 2048, n);
    rd("warm_back", 8'h0c, 32'h1, 32'hff);
    STOP_RELEASE <= 1'b0;
    rd("stop_clr", 8'h00, 32'h3, '1);
    $display("test stop done");
  endtask

  // Reset, then every scenario in turn
  initial begin
    SRST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h0;
    PWDATA = 32'h0;
    STOP_RELEASE = 1'b0;
    INTERRUPT_MASTER_ENABLE = 1'b0;
    INSTR_LEN = 4'h1;
    want_irq = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    repeat (6) @(posedge CLK);
    SRST <= 1'b0;
    t_reset;
    t_instr;
    t_idle;
    t_low;
    t_stop;
    close_out;
  end
endmodule // tb_top
